/* bench/sit_pin_src.sv */
/*
 sit_pin_src: far-side source of the count pin and the gate pin.
 Assumes its tasks are called right after a rising sys_clk edge.
*/
`timescale 1ns/1ps
module sit_pin_src (
	// clock
	input wire logic sys_clk,
	// pins
	output logic extCountPin,
	output logic gatePin
);
	// both pins idle low
	initial begin
		extCountPin = 1'b0;
		gatePin = 1'b0;
	end
	// pulses wide enough for the two sync flops
	task automatic pulse(input int n);
		repeat (n) begin
			extCountPin <= 1'b1;
			repeat (3) @(posedge sys_clk);
			extCountPin <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
	endtask
	task automatic gate(input logic lvl);
		gatePin <= lvl;
		@(posedge sys_clk);
	endtask
endmodule

/* bench/sit_timer_test.sv */
/*
 sit_timer_test: self-checking bench of the interval timer over APB.
 Assumes pready may wait; each bus task starts after a rising edge.
*/
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %h got %h", nm, e, a); end end
module sit_timer_test;
	import sit_pkg::*;
	logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat, w;
	logic pready, pslverr, rerr, tickIrq, extCountPin, gatePin;
	logic idleMode = 1'b0, sleepMode = 1'b0;
	int fail_count = 0, n_tests = 0, seed = 32'h5673f169;
	always #20 sys_clk = ~sys_clk;
	sit_timer sit_timer_inst (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .idleMode(idleMode),
		.sleepMode(sleepMode), .extCountPin(extCountPin), .gatePin(gatePin),
		.tickIrq(tickIrq));
	sit_pin_src sit_pin_src_inst (.sys_clk(sys_clk), .extCountPin(extCountPin),
		.gatePin(gatePin));
	// one transfer, then one idle cycle so psel never toggles twice at once
	task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {3'h0, a}; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// wait for the answer; only the watchdog ends a hung wait
		do begin @(posedge sys_clk); end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	// expected ticks over n enabled cycles at prescale code ps
	function automatic logic [15:0] ticks(input int n, input logic [1:0] ps);
		return 16'((n) >> (ps == 2'd0 ? 0 : ps == 2'd1 ? 3 : ps == 2'd2 ? 6 : 8));
	endfunction
	// start and stop edges are known only to within one cycle
	function automatic logic near(input logic [15:0] e, input logic [15:0] a);
		return (a === e) || (a === e + 16'h1) || (a + 16'h1 === e);
	endfunction
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog
	initial begin
		#2000000;
		fail_count++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		apb(0, OFS_CTRL, 0); `CHK("ctrl rst", 32'h0, rdat)
		apb(0, OFS_PERIOD, 0); `CHK("period rst", 32'hFFFF, rdat)
		apb(1, OFS_CTRL, 32'hFFFF); apb(0, OFS_CTRL, 0);
		`CHK("ctrl mask", 32'hA076, rdat)
		apb(1, OFS_CTRL, 0);
		apb(0, 5'h14, 0); `CHK("unmapped", 33'h100000000, {rerr, rdat})
		// every prescale ratio over a random span
		for (int ps = 0; ps < 4; ps++) begin
			w = 256 + ($random(seed) & 511);
			apb(1, OFS_COUNT, 0);
			apb(1, OFS_CTRL, 32'h8000 | (ps << 4));
			repeat (w) @(posedge sys_clk);
			apb(1, OFS_CTRL, 0); apb(0, OFS_COUNT, 0);
			`CHK("prescale", 1'b1, near(ticks(w + 3, 2'(ps)), rdat[15:0]))
			w = rdat;
			apb(0, OFS_COUNT, 0); `CHK("stopped", w, rdat)
		end
		// period match, mask and clear
		w = 3 + ($random(seed) & 7);
		apb(1, OFS_PERIOD, w);
		apb(1, OFS_MASK, 1);
		apb(1, OFS_CTRL, 32'h8000);
		repeat (30) @(posedge sys_clk);
		`CHK("irq", 1'b1, tickIrq)
		apb(1, OFS_CTRL, 0); apb(0, OFS_STATUS, 0); `CHK("match", 32'h1, rdat)
		apb(0, OFS_COUNT, 0); `CHK("wrap", 1'b1, rdat <= w)
		w = rdat;
		apb(0, OFS_COUNT, 0); `CHK("halted", w, rdat)
		apb(1, OFS_MASK, 0); `CHK("masked", 1'b0, tickIrq)
		apb(1, OFS_STATUS, 1); apb(0, OFS_STATUS, 0); `CHK("w1c", 32'h0, rdat)
		apb(1, OFS_PERIOD, 32'hFFFF);
		// external edges, both sync modes; gate bit ignored here
		for (int s = 0; s < 2; s++) begin
			apb(1, OFS_COUNT, 0); apb(1, OFS_CTRL, 32'h8042 | (s << 2));
			sit_pin_src_inst.pulse(5);
			repeat (6) @(posedge sys_clk);
			apb(1, OFS_CTRL, 0); apb(0, OFS_COUNT, 0);
			`CHK("ext count", 32'h5, rdat)
		end
		// gated accumulation
		apb(1, OFS_COUNT, 0); apb(1, OFS_CTRL, 32'h8040);
		repeat (20) @(posedge sys_clk);
		apb(0, OFS_COUNT, 0); `CHK("gate low", 32'h0, rdat)
		apb(1, OFS_MASK, 2);
		sit_pin_src_inst.gate(1'b1);
		repeat (20) @(posedge sys_clk);
		sit_pin_src_inst.gate(1'b0);
		repeat (6) @(posedge sys_clk);
		apb(0, OFS_STATUS, 0); `CHK("gate fall", 32'h2, rdat)
		`CHK("gate irq", 1'b1, tickIrq)
		apb(0, OFS_COUNT, 0); `CHK("gate high", 1'b1, rdat > 0)
		apb(1, OFS_CTRL, 0); apb(1, OFS_STATUS, 3);
		// idle halt versus idle run
		idleMode <= 1'b1;
		apb(1, OFS_COUNT, 0); apb(1, OFS_CTRL, 32'hA000);
		repeat (20) @(posedge sys_clk);
		apb(0, OFS_COUNT, 0); `CHK("idle halt", 1'b1, rdat < 3)
		apb(1, OFS_CTRL, 32'h8000);
		repeat (20) @(posedge sys_clk);
		apb(0, OFS_COUNT, 0); `CHK("idle run", 1'b1, rdat > 20)
		idleMode <= 1'b0;
		// sleep: the internal clock stops, an unsynchronised pin still counts
		sleepMode <= 1'b1;
		apb(1, OFS_COUNT, 0);
		repeat (20) @(posedge sys_clk);
		apb(0, OFS_COUNT, 0); `CHK("sleep int", 32'h0, rdat)
		apb(1, OFS_CTRL, 32'h8002);
		sit_pin_src_inst.pulse(3);
		repeat (6) @(posedge sys_clk);
		apb(1, OFS_CTRL, 0); apb(0, OFS_COUNT, 0); `CHK("sleep ext", 32'h3, rdat)
		sleepMode <= 1'b0;
		// reset in mid-run with the interrupt up
		apb(1, OFS_COUNT, 0); apb(1, OFS_PERIOD, 2);
		apb(1, OFS_MASK, 1); apb(1, OFS_CTRL, 32'h8000);
		repeat (10) @(posedge sys_clk);
		`CHK("pre rst irq", 1'b1, tickIrq)
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		`CHK("rst irq", 1'b0, tickIrq)
		resetn <= 1'b1;
		@(posedge sys_clk);
		apb(0, OFS_CTRL, 0); `CHK("rst ctrl", 32'h0, rdat)
		apb(0, OFS_COUNT, 0); `CHK("rst count", 32'h0, rdat)
		end_sim();
	end
endmodule

/* pkg/sit_pkg.sv */
/*
 sit_pkg: register map, control field positions, reset values, prescale
 limits, run states and the packed state record of the interval timer.
 Assumes a 32-bit APB slave with byte addresses of one aligned word each.
*/
package sit_pkg;
	// register byte offsets, one 32-bit word each
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_PERIOD = 5'h04;
	localparam logic [4:0] OFS_COUNT = 5'h08;
	localparam logic [4:0] OFS_STATUS = 5'h0C;
	localparam logic [4:0] OFS_MASK = 5'h10;
	localparam int unsigned NUM_REGS = 5;
	localparam int unsigned OFS_W = 5;

	// control register bit positions
	localparam int unsigned BIT_RUN = 15;
	localparam int unsigned BIT_IDLE = 13;
	localparam int unsigned BIT_GATE = 6;
	localparam int unsigned BIT_PS_HI = 5;
	localparam int unsigned BIT_PS_LO = 4;
	localparam int unsigned BIT_SYNC = 2;
	localparam int unsigned BIT_SRC = 1;

	// reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] PERIOD_RST = 16'hFFFF;

	// prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
	localparam logic [7:0] PS_LIM_1 = 8'h00;
	localparam logic [7:0] PS_LIM_8 = 8'h07;
	localparam logic [7:0] PS_LIM_64 = 8'h3F;
	localparam logic [7:0] PS_LIM_256 = 8'hFF;

	// interrupt status / mask bits
	localparam int unsigned IRQ_W = 2;
	localparam int unsigned IRQ_MATCH = 0;
	localparam int unsigned IRQ_GATE = 1;

	typedef enum logic [1:0] {
		SIT_STOPPED = 2'b00,
		SIT_RUNNING = 2'b01,
		SIT_HALTED = 2'b11
	} sit_run_e;

	typedef struct packed {
		logic runBit;
		logic idleHalt;
		logic gateAccumEn;
		logic [1:0] prescaleSel;
		logic extClkSync;
		logic clkSrcSel;
	} sit_ctrl_s;

	typedef struct packed {
		sit_ctrl_s ctrl;
		logic [15:0] period;
		logic [15:0] count;
		logic [7:0] presc;
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
		sit_run_e run;
		logic extMeta;
		logic extSync;
		logic extDly;
		logic extRiseS;
		logic gateMeta;
		logic gateSync;
		logic gateDly;
		logic [31:0] rdata;
		logic slvErr;
		logic irq;
	} sit_state_s;
endpackage

/* rtl/sit_timer.sv */
/*
 sit_timer: 16-bit interval timer / counter with prescaler, gated
 accumulation, internal or external count clock, sticky interrupt status
 with mask, and an APB register slave.
 Assumes: one clock sys_clk (the instruction-cycle clock), idleMode and
 sleepMode from same-clock power logic, count and gate pins asynchronous.
*/
// Local design decisions: the APB slave port and the register addresses.
// Function
// - The block holds a 16-bit counter usable as timer, synchronous counter or asynchronous counter.
// - An interrupt is raised on period match outside gated mode, or on the gate falling edge in gated mode.
// - Control bit 15 starts the counter when one and stops it when zero.
// - Control bit 13 set halts the counter in Idle mode; clear lets it run on.
// - Control bit 6 enables gated accumulation only with the internal clock selected.
// - Control bits 5-4 divide the count clock by 1, 8, 64 or 256.
// - Control bit 2 synchronises the external clock when set, and is ignored for internal.
// - Control bit 1 selects external pin rising edges when set, internal clock when clear.
// - Control bits 14, 12-7, 3 and 0 read zero and ignore writes.
// - Implemented control bits are read/write and reset to zero, so the counter starts stopped.
// - The counter can keep counting in Idle, subject to the idle halt bit, and in Sleep only on unsynchronised external pin edges.
`timescale 1ns/1ps
module sit_timer
	import sit_pkg::*;
#(
	parameter int unsigned ADDR_W = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// power state from the core
	input wire logic idleMode,
	input wire logic sleepMode,
	// pins
	input wire logic extCountPin,
	input wire logic gatePin,
	// interrupt
	output logic tickIrq
);
	// elaboration check: the register window needs the offset bits
	if (ADDR_W < OFS_W + 1) begin : g_bad_addr
		$error("sit_timer: ADDR_W too small for register map");
	end

	sit_state_s s_q;
	sit_state_s s_d;

	logic [NUM_REGS-1:0] hit;
	logic setupPh;
	logic wrAcc;
	logic gatedMode;
	logic extRiseFast;
	logic gateFall;
	logic cntEn;
	logic tick;
	logic atPeriod;
	logic [7:0] psLim;
	logic evMatch;
	logic evGate;

	// one-hot register decode, shared by read and write paths
	function automatic logic [NUM_REGS-1:0] addrHit(input logic [ADDR_W-1:0] a);
		logic [NUM_REGS-1:0] h;
		logic [OFS_W-1:0] lo;
		h = '0;
		lo = a[OFS_W-1:0];
		if (a[ADDR_W-1:OFS_W] == '0) begin
			h[0] = (lo == OFS_CTRL);
			h[1] = (lo == OFS_PERIOD);
			h[2] = (lo == OFS_COUNT);
			h[3] = (lo == OFS_STATUS);
			h[4] = (lo == OFS_MASK);
		end
		return h;
	endfunction

	// control word image; unimplemented bits stay zero
	function automatic logic [15:0] packCtrl(input sit_ctrl_s c);
		logic [15:0] w;
		w = CTRL_RST;
		w[BIT_RUN] = c.runBit;
		w[BIT_IDLE] = c.idleHalt;
		w[BIT_GATE] = c.gateAccumEn;
		w[BIT_PS_HI:BIT_PS_LO] = c.prescaleSel;
		w[BIT_SYNC] = c.extClkSync;
		w[BIT_SRC] = c.clkSrcSel;
		return w;
	endfunction

	// prescale select to terminal count
	function automatic logic [7:0] psLimit(input logic [1:0] sel);
		logic [7:0] l;
		case (sel)
			2'b00: l = PS_LIM_1;
			2'b01: l = PS_LIM_8;
			2'b10: l = PS_LIM_64;
			default: l = PS_LIM_256;
		endcase
		return l;
	endfunction

	// bus phase decode
	assign hit = addrHit(paddr);
	assign setupPh = psel && !penable;
	assign wrAcc = psel && penable && pwrite;

	// zero-wait slave: read data is captured in the setup cycle
	assign pready = 1'b1;
	assign prdata = s_q.rdata;
	assign pslverr = s_q.slvErr;
	assign tickIrq = s_q.irq;

	// gating only counts with the internal clock
	assign gatedMode = s_q.ctrl.gateAccumEn && !s_q.ctrl.clkSrcSel;
	assign extRiseFast = s_q.extSync && !s_q.extDly;
	assign gateFall = s_q.gateDly && !s_q.gateSync;

	// prescaler input: internal clock stops in sleep, unsynchronised pin does not
	always_comb begin
		cntEn = 1'b0;
		if (s_q.run == SIT_RUNNING) begin
			if (s_q.ctrl.clkSrcSel) begin
				if (s_q.ctrl.extClkSync) begin
					cntEn = s_q.extRiseS && !sleepMode;
				end else begin
					cntEn = extRiseFast;
				end
			end else begin
				cntEn = !sleepMode && (!gatedMode || s_q.gateSync);
			end
		end
	end

	// prescaled tick and period compare
	assign psLim = psLimit(s_q.ctrl.prescaleSel);
	assign tick = cntEn && (s_q.presc >= psLim);
	assign atPeriod = (s_q.count == s_q.period);
	assign evMatch = tick && atPeriod && !gatedMode;
	assign evGate = gateFall && gatedMode && (s_q.run != SIT_STOPPED);

	// next-state logic for the whole block
	always_comb begin
		logic [IRQ_W-1:0] w1c;
		w1c = '0;
		s_d = s_q;

		// two-flop synchronisers, third stage only for edge detect
		s_d.extMeta = extCountPin;
		s_d.extSync = s_q.extMeta;
		s_d.extDly = s_q.extSync;
		s_d.extRiseS = extRiseFast; // extra stage aligns the edge to sys_clk
		s_d.gateMeta = gatePin;
		s_d.gateSync = s_q.gateMeta;
		s_d.gateDly = s_q.gateSync;

		// prescaler clears while stopped so a restart begins a full period
		if (s_q.run == SIT_STOPPED) begin
			s_d.presc = '0;
		end else if (cntEn) begin
			if (s_q.presc >= psLim) begin
				s_d.presc = '0;
			end else begin
				s_d.presc = s_q.presc + 8'h01;
			end
		end

		// counter: wraps to zero on the tick where it equals the period
		if (tick) begin
			if (atPeriod) begin
				s_d.count = '0;
			end else begin
				s_d.count = s_q.count + 16'h0001;
			end
		end

		// read capture in the setup cycle
		if (setupPh) begin
			s_d.slvErr = (hit == '0);
			s_d.rdata = '0;
			case (1'b1)
				hit[0]: s_d.rdata[15:0] = packCtrl(s_q.ctrl);
				hit[1]: s_d.rdata[15:0] = s_q.period;
				hit[2]: s_d.rdata[15:0] = s_q.count;
				hit[3]: s_d.rdata[IRQ_W-1:0] = s_q.status;
				hit[4]: s_d.rdata[IRQ_W-1:0] = s_q.mask;
				default: s_d.rdata = '0;
			endcase
		end

		// writes in the access phase; software write beats a tick
		if (wrAcc) begin
			case (1'b1)
				hit[0]: begin
					s_d.ctrl.runBit = pwdata[BIT_RUN];
					s_d.ctrl.idleHalt = pwdata[BIT_IDLE];
					s_d.ctrl.gateAccumEn = pwdata[BIT_GATE];
					s_d.ctrl.prescaleSel = pwdata[BIT_PS_HI:BIT_PS_LO];
					s_d.ctrl.extClkSync = pwdata[BIT_SYNC];
					s_d.ctrl.clkSrcSel = pwdata[BIT_SRC];
				end
				hit[1]: s_d.period = pwdata[15:0];
				hit[2]: s_d.count = pwdata[15:0];
				hit[3]: w1c = pwdata[IRQ_W-1:0];
				hit[4]: s_d.mask = pwdata[IRQ_W-1:0];
				default: w1c = '0;
			endcase
		end

		// run state follows the control word as written, so a stop lands on the write edge
		if (!s_d.ctrl.runBit) begin
			s_d.run = SIT_STOPPED;
		end else if (idleMode && s_d.ctrl.idleHalt) begin
			s_d.run = SIT_HALTED;
		end else begin
			s_d.run = SIT_RUNNING;
		end

		// sticky status, a new event wins over a clear in the same cycle
		s_d.status = (s_q.status & ~w1c);
		s_d.status[IRQ_MATCH] = s_d.status[IRQ_MATCH] | evMatch;
		s_d.status[IRQ_GATE] = s_d.status[IRQ_GATE] | evGate;
		s_d.irq = |(s_d.status & s_d.mask);
	end

	// state register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.period <= PERIOD_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	logic wrCount;
	assign wrCount = wrAcc && hit[2];

	AST_STOP_HOLDS: assert property (
		(!s_q.ctrl.runBit && !wrCount) |=> $stable(s_q.count))
		else $error("count moved while stopped");

	AST_CTRL_RSV: assert property (
		setupPh && hit[0] |=> (prdata[14] == 1'b0) && (prdata[12:7] == 6'h00)
			&& (prdata[3] == 1'b0) && (prdata[0] == 1'b0))
		else $error("reserved control bit read as one");

	AST_IDLE_HALT: assert property (
		(s_q.run == SIT_HALTED && !wrCount) |=> $stable(s_q.count))
		else $error("count moved while halted in idle");

	AST_IDLE_ENTRY: assert property (
		(s_q.ctrl.runBit && s_q.ctrl.idleHalt && idleMode && !wrAcc)
			|=> (s_q.run == SIT_HALTED))
		else $error("idle halt not entered");

	AST_WRAP: assert property (
		(tick && atPeriod && !wrCount) |=> (s_q.count == 16'h0000))
		else $error("count did not wrap at period");

	AST_INC: assert property (
		(tick && !atPeriod && !wrCount) |=> (s_q.count == $past(s_q.count) + 16'h0001))
		else $error("count did not step by one");

	AST_MATCH_FLAG: assert property (
		(tick && atPeriod && !gatedMode) |=> s_q.status[IRQ_MATCH])
		else $error("match flag not set");

	AST_GATE_LOW: assert property (
		(gatedMode && !s_q.gateSync) |-> !cntEn)
		else $error("counted with gate low");

	AST_PRESC8: assert property (
		(tick && s_q.ctrl.prescaleSel == 2'b01 && !s_q.ctrl.clkSrcSel && !wrAcc)
			|=> !tick [*7])
		else $error("1:8 prescale ticked early");

	AST_EXT_EDGE: assert property (
		(s_q.ctrl.clkSrcSel && !s_q.ctrl.extClkSync && !extRiseFast) |-> !cntEn)
		else $error("external count without a pin edge");

	AST_SYNC_EDGE: assert property (
		(s_q.ctrl.clkSrcSel && s_q.ctrl.extClkSync && cntEn) |-> $past(extRiseFast))
		else $error("synchronised count not from delayed edge");

	AST_IRQ_OUT: assert property (
		(evGate && s_q.mask[IRQ_GATE]) |=> tickIrq)
		else $error("unmasked gate event gave no interrupt");

	AST_RUN_STOP: assert property (
		!s_q.ctrl.runBit |-> (s_q.run == SIT_STOPPED))
		else $error("run state active with run bit clear");

	AST_CTRL_WR: assert property (
		(wrAcc && hit[0]) |=> (s_q.ctrl.runBit == $past(pwdata[BIT_RUN])))
		else $error("control write not taken");

	AST_PERIOD_WR: assert property (
		(wrAcc && hit[1]) |=> (s_q.period == $past(pwdata[15:0])))
		else $error("period write not taken");

	AST_INT_SLEEP: assert property (
		(!s_q.ctrl.clkSrcSel && sleepMode) |-> !cntEn)
		else $error("internal clock counted in sleep");

	AST_ASYNC_RUN: assert property (
		(s_q.run == SIT_RUNNING && s_q.ctrl.clkSrcSel && !s_q.ctrl.extClkSync
			&& extRiseFast) |-> cntEn)
		else $error("unsynchronised pin edge not counted");

	AST_GATE_FLAG: assert property (
		evGate |=> s_q.status[IRQ_GATE])
		else $error("gate flag not set");

	AST_GATED_NOMATCH: assert property (
		gatedMode |=> !$rose(s_q.status[IRQ_MATCH]))
		else $error("match flag set in gated mode");

	AST_W1C: assert property (
		(wrAcc && hit[3] && pwdata[IRQ_MATCH] && !evMatch) |=> !s_q.status[IRQ_MATCH])
		else $error("status bit not cleared by writing one");

	AST_IRQ_LEVEL: assert property (
		tickIrq == |(s_q.status & s_q.mask))
		else $error("interrupt level differs from status and mask");

	COV_WRAP: cover property (tick && atPeriod);
	COV_SLEEP_EXT: cover property (sleepMode && tick);
	COV_GATE_FALL: cover property (evGate);
	COV_EXT_ASYNC: cover property (s_q.ctrl.clkSrcSel && !s_q.ctrl.extClkSync && tick);
	COV_IDLE_HALT: cover property (s_q.run == SIT_HALTED);
endmodule
